// file: design/adbis_pkg.sv
package adbis_pkg;

  // ---------------------------------------------------------------------------
  // Memory geometry
  // ---------------------------------------------------------------------------
  localparam int MEM_AW = 6;
  localparam int MEM_DEPTH = 64;
  localparam int PROG_W = 32;
  localparam int PARAM_W = 28;
  localparam int DATA_W = 28;
  localparam int CTRL_N = 8;
  localparam int CTRL_AW = 3;
  localparam int CTRL_W = 16;
  localparam int WORD_W = 32;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int PLL_LOCK_EDGES = 262144;
  localparam int PLL_CNT_W = 19;
  localparam int BOOT_CYCLES = 2048;
  localparam int BOOT_CNT_W = 12;

  // ---------------------------------------------------------------------------
  // Clock-ratio select codes and input-clock multiples of the sample rate
  // ---------------------------------------------------------------------------
  localparam logic [1:0] RATIO_64 = 2'h0;
  localparam logic [1:0] RATIO_256 = 2'h1;
  localparam logic [1:0] RATIO_384 = 2'h2;
  localparam logic [1:0] RATIO_512 = 2'h3;
  localparam logic [9:0] MULT_64 = 10'h040;
  localparam logic [9:0] MULT_256 = 10'h100;
  localparam logic [9:0] MULT_384 = 10'h180;
  localparam logic [9:0] MULT_512 = 10'h200;

  // ---------------------------------------------------------------------------
  // Default program encoding: one route instruction per word
  // ---------------------------------------------------------------------------
  localparam logic [3:0] OP_ROUTE = 4'h1;
  localparam logic [3:0] SRC_SDIN0 = 4'h0;
  localparam logic [3:0] SRC_SDIN1 = 4'h1;
  localparam logic [3:0] SRC_ADC0 = 4'h2;
  localparam logic [3:0] SRC_ADC1 = 4'h3;
  localparam logic [3:0] DST_DAC0 = 4'h0;
  localparam logic [3:0] DST_DAC1 = 4'h1;
  localparam logic [3:0] DST_DAC2 = 4'h2;
  localparam logic [3:0] DST_DAC3 = 4'h3;
  localparam logic [3:0] DST_SDOUT0 = 4'h4;
  localparam logic [3:0] DST_SDOUT1 = 4'h5;
  localparam logic [19:0] ROUTE_PAD = 20'h00000;
  localparam logic [PROG_W-1:0] PROG_NOP = 32'h00000000;
  localparam logic [PARAM_W-1:0] PARAM_UNITY = 28'h0800000;
  localparam logic [PARAM_W-1:0] PARAM_ZERO = 28'h0000000;
  localparam logic [MEM_AW-1:0] ROUTE_COUNT = 6'h06;

  typedef enum logic [1:0] {
    MEM_PROG = 2'h0,
    MEM_PARAM = 2'h1,
    MEM_DATA = 2'h2,
    MEM_CTRL = 2'h3
  } adbis_mem_type;

  typedef enum logic [3:0] {
    ST_HOLD = 4'h1,
    ST_PLL = 4'h2,
    ST_BOOT = 4'h4,
    ST_RUN = 4'h8
  } adbis_state_type;

  typedef struct packed {
    logic en;
    logic wr;
    adbis_mem_type sel;
    logic [MEM_AW-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } adbis_req_type;

  typedef struct packed {
    logic init_done;
    logic core_reset;
    logic [1:0] ratio_sel;
    logic [9:0] in_multiple;
  } adbis_status_type;

  function automatic logic [PROG_W-1:0] prog_rom(input logic [MEM_AW-1:0] a);
    logic [PROG_W-1:0] w;
    w = PROG_NOP;
    unique case (a)
      6'h00: w = {OP_ROUTE, ROUTE_PAD, SRC_SDIN0, DST_DAC0};
      6'h01: w = {OP_ROUTE, ROUTE_PAD, SRC_SDIN1, DST_DAC1};
      6'h02: w = {OP_ROUTE, ROUTE_PAD, SRC_SDIN0, DST_SDOUT0};
      6'h03: w = {OP_ROUTE, ROUTE_PAD, SRC_SDIN1, DST_SDOUT1};
      6'h04: w = {OP_ROUTE, ROUTE_PAD, SRC_ADC0, DST_DAC2};
      6'h05: w = {OP_ROUTE, ROUTE_PAD, SRC_ADC1, DST_DAC3};
      default: w = PROG_NOP;
    endcase
    return w;
  endfunction : prog_rom

  function automatic logic [PARAM_W-1:0] param_rom(input logic [MEM_AW-1:0] a);
    return (a < ROUTE_COUNT) ? PARAM_UNITY : PARAM_ZERO;
  endfunction : param_rom

endpackage : adbis_pkg

// file: design/adbis_ram.sv
`timescale 1ns/1ps

module adbis_ram #(
  parameter int AW = 6,
  parameter int W = 32
) (
  input wire logic ref_clk_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [W-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [W-1:0] rdata_o
);

  logic [W-1:0] mem [0:(1<<AW)-1];

  // Read data is registered so that callers see a fixed one-cycle latency.
  always_ff @(posedge ref_clk_i)
  begin
    if (we_i)
    begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end

endmodule : adbis_ram

// file: design/adbis_seq.sv
`timescale 1ns/1ps

module adbis_seq #(
  parameter int PLL_LOCK_EDGES = adbis_pkg::PLL_LOCK_EDGES
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic active_low_reset_in_i,
  input wire logic clock_ratio_select_lo_i,
  input wire logic clock_ratio_select_hi_i,
  input wire logic master_clock_in_i,
  input wire adbis_pkg::adbis_req_type core_req_i,
  output adbis_pkg::adbis_status_type status_o,
  output logic [adbis_pkg::WORD_W-1:0] core_rdata_o,
  output logic core_rvalid_o,
  output logic [adbis_pkg::CTRL_N-1:0][adbis_pkg::CTRL_W-1:0] ctrl_regs_o
);

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  logic [2:0] rst_pin_reg;
  logic [2:0] mclk_reg;
  logic [1:0] mode_meta_reg;
  logic [1:0] mode_sync_reg;

  always_ff @(posedge ref_clk_i)
  begin
    rst_pin_reg <= {rst_pin_reg[1:0], active_low_reset_in_i};
    mclk_reg <= {mclk_reg[1:0], master_clock_in_i};
    mode_meta_reg <= {clock_ratio_select_hi_i, clock_ratio_select_lo_i};
    mode_sync_reg <= mode_meta_reg;
  end

  wire pin_high = rst_pin_reg[1];
  wire mclk_rise = mclk_reg[1] & ~mclk_reg[2];

  // ---------------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------------
  adbis_pkg::adbis_state_type state_reg;
  adbis_pkg::adbis_state_type state_next;
  logic [adbis_pkg::PLL_CNT_W-1:0] pll_cnt_reg;
  logic [adbis_pkg::BOOT_CNT_W-1:0] boot_cnt_reg;

  wire in_hold = (state_reg == adbis_pkg::ST_HOLD);
  wire in_pll = (state_reg == adbis_pkg::ST_PLL);
  wire in_boot = (state_reg == adbis_pkg::ST_BOOT);
  wire in_run = (state_reg == adbis_pkg::ST_RUN);
  wire pll_locked = mclk_rise & (pll_cnt_reg == adbis_pkg::PLL_CNT_W'(PLL_LOCK_EDGES - 1));
  wire boot_last = (boot_cnt_reg == adbis_pkg::BOOT_CNT_W'(adbis_pkg::BOOT_CYCLES - 1));
  wire boot_fill = in_boot & (boot_cnt_reg < adbis_pkg::BOOT_CNT_W'(adbis_pkg::MEM_DEPTH));
  wire [adbis_pkg::MEM_AW-1:0] boot_addr = boot_cnt_reg[adbis_pkg::MEM_AW-1:0];

  // A low reset pin forces the hold state from anywhere; leaving hold needs the
  // pin high, which covers both power-up with the pin high and a rising edge.
  always_comb
  begin
    state_next = state_reg;
    if (!pin_high)
    begin
      state_next = adbis_pkg::ST_HOLD;
    end
    else
    begin
      unique case (state_reg)
        adbis_pkg::ST_HOLD: state_next = adbis_pkg::ST_PLL;
        adbis_pkg::ST_PLL: state_next = pll_locked ? adbis_pkg::ST_BOOT : adbis_pkg::ST_PLL;
        adbis_pkg::ST_BOOT: state_next = boot_last ? adbis_pkg::ST_RUN : adbis_pkg::ST_BOOT;
        adbis_pkg::ST_RUN: state_next = adbis_pkg::ST_RUN;
        default: state_next = adbis_pkg::ST_HOLD;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= adbis_pkg::ST_HOLD;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Start-up counter counts rising edges of the input clock, not ref_clk.
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i || !in_pll)
    begin
      pll_cnt_reg <= '0;
    end
    else if (mclk_rise)
    begin
      pll_cnt_reg <= pll_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i || !in_boot)
    begin
      boot_cnt_reg <= '0;
    end
    else
    begin
      boot_cnt_reg <= boot_cnt_reg + 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Clock mode capture
  // ---------------------------------------------------------------------------
  logic [1:0] ratio_reg;
  logic [9:0] mult_reg;
  logic [9:0] mult_next;

  always_comb
  begin
    unique case (mode_sync_reg)
      adbis_pkg::RATIO_64: mult_next = adbis_pkg::MULT_64;
      adbis_pkg::RATIO_256: mult_next = adbis_pkg::MULT_256;
      adbis_pkg::RATIO_384: mult_next = adbis_pkg::MULT_384;
      adbis_pkg::RATIO_512: mult_next = adbis_pkg::MULT_512;
    endcase
  end

  // The pins are only sampled when reset is left, so a change while running
  // cannot disturb the clock until the next reset.
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      ratio_reg <= adbis_pkg::RATIO_64;
      mult_reg <= adbis_pkg::MULT_64;
    end
    else if (in_hold && pin_high)
    begin
      ratio_reg <= mode_sync_reg;
      mult_reg <= mult_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Internal master clock phase and core reset
  // ---------------------------------------------------------------------------
  logic phase_reg;
  logic core_rst_reg;
  logic done_reg;

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      phase_reg <= 1'b0;
      core_rst_reg <= 1'b1;
      done_reg <= 1'b0;
    end
    else
    begin
      phase_reg <= ~phase_reg;
      if (!in_run)
      begin
        core_rst_reg <= 1'b1;
      end
      else if (phase_reg)
      begin
        core_rst_reg <= 1'b0;
      end
      done_reg <= in_boot ? boot_last : in_run;
    end
  end

  // ---------------------------------------------------------------------------
  // Memories
  // ---------------------------------------------------------------------------
  // Core requests are refused until init is done, so early host traffic
  // cannot race the boot fill.
  wire core_ok = in_run & core_req_i.en;
  wire core_wr = core_ok & core_req_i.wr;
  wire core_rd = core_ok & ~core_req_i.wr;
  wire data_we = boot_fill | (core_wr & (core_req_i.sel == adbis_pkg::MEM_DATA));
  wire [adbis_pkg::MEM_AW-1:0] data_wa = in_boot ? boot_addr : core_req_i.addr;
  wire [adbis_pkg::DATA_W-1:0] data_wd = in_boot ? '0 : core_req_i.wdata[adbis_pkg::DATA_W-1:0];
  wire [adbis_pkg::PROG_W-1:0] prog_rdata;
  wire [adbis_pkg::PARAM_W-1:0] param_rdata;
  wire [adbis_pkg::DATA_W-1:0] data_rdata;

  adbis_ram #(.AW(adbis_pkg::MEM_AW), .W(adbis_pkg::PROG_W)) u_prog_ram (
    .ref_clk_i(ref_clk_i),
    .we_i(boot_fill),
    .waddr_i(boot_addr),
    .wdata_i(adbis_pkg::prog_rom(boot_addr)),
    .raddr_i(core_req_i.addr),
    .rdata_o(prog_rdata)
  );

  adbis_ram #(.AW(adbis_pkg::MEM_AW), .W(adbis_pkg::PARAM_W)) u_param_ram (
    .ref_clk_i(ref_clk_i),
    .we_i(boot_fill),
    .waddr_i(boot_addr),
    .wdata_i(adbis_pkg::param_rom(boot_addr)),
    .raddr_i(core_req_i.addr),
    .rdata_o(param_rdata)
  );

  adbis_ram #(.AW(adbis_pkg::MEM_AW), .W(adbis_pkg::DATA_W)) u_data_ram (
    .ref_clk_i(ref_clk_i),
    .we_i(data_we),
    .waddr_i(data_wa),
    .wdata_i(data_wd),
    .raddr_i(core_req_i.addr),
    .rdata_o(data_rdata)
  );

  // ---------------------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------------------
  logic [adbis_pkg::CTRL_N-1:0][adbis_pkg::CTRL_W-1:0] ctrl_reg;
  wire [adbis_pkg::CTRL_AW-1:0] ctrl_idx = core_req_i.addr[adbis_pkg::CTRL_AW-1:0];
  wire ctrl_we = core_wr & (core_req_i.sel == adbis_pkg::MEM_CTRL);

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i || in_boot)
    begin
      ctrl_reg <= '0;
    end
    else if (ctrl_we)
    begin
      ctrl_reg[ctrl_idx] <= core_req_i.wdata[adbis_pkg::CTRL_W-1:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Read path: request, RAM register, output register
  // ---------------------------------------------------------------------------
  logic rd_pend_reg;
  adbis_pkg::adbis_mem_type sel_d_reg;
  logic [adbis_pkg::CTRL_W-1:0] ctrl_rd_reg;
  logic [adbis_pkg::WORD_W-1:0] rdata_reg;
  logic rvalid_reg;
  logic [adbis_pkg::WORD_W-1:0] rdata_mux;

  always_comb
  begin
    unique case (sel_d_reg)
      adbis_pkg::MEM_PROG: rdata_mux = prog_rdata;
      adbis_pkg::MEM_PARAM: rdata_mux = {4'h0, param_rdata};
      adbis_pkg::MEM_DATA: rdata_mux = {4'h0, data_rdata};
      adbis_pkg::MEM_CTRL: rdata_mux = {16'h0000, ctrl_rd_reg};
    endcase
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      rd_pend_reg <= 1'b0;
      sel_d_reg <= adbis_pkg::MEM_PROG;
      ctrl_rd_reg <= '0;
      rdata_reg <= '0;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      rd_pend_reg <= core_rd;
      sel_d_reg <= core_req_i.sel;
      ctrl_rd_reg <= ctrl_reg[ctrl_idx];
      rvalid_reg <= rd_pend_reg;
      if (rd_pend_reg)
      begin
        rdata_reg <= rdata_mux;
      end
    end
  end

  assign status_o = '{init_done: done_reg, core_reset: core_rst_reg, ratio_sel: ratio_reg, in_multiple: mult_reg};
  assign core_rdata_o = rdata_reg;
  assign core_rvalid_o = rvalid_reg;
  assign ctrl_regs_o = ctrl_reg;

endmodule : adbis_seq

// file: testbench/adbis_seq_props.sv
`timescale 1ns/1ps

module adbis_seq_props #(
  parameter int PLL_LOCK_EDGES = adbis_pkg::PLL_LOCK_EDGES
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic active_low_reset_in_i,
  input wire adbis_pkg::adbis_req_type core_req_i,
  input wire adbis_pkg::adbis_status_type status_o,
  input wire logic core_rvalid_o,
  input wire logic [adbis_pkg::CTRL_N-1:0][adbis_pkg::CTRL_W-1:0] ctrl_regs_o
);
  localparam int MIN_BOOT = adbis_pkg::BOOT_CYCLES + PLL_LOCK_EDGES;
  logic [19:0] pin_cnt_reg;
  logic [9:0] mult_exp;

  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  // Counts edges since the reset pin went high; saturates so a long run never wraps.
  always_ff @(posedge ref_clk_i)
    if (rst_i || !active_low_reset_in_i)
      pin_cnt_reg <= 20'h00000;
    else if (!pin_cnt_reg[19])
      pin_cnt_reg <= pin_cnt_reg + 20'h00001;

  assign mult_exp = (status_o.ratio_sel == 2'h0) ? 10'h040 : (status_o.ratio_sel == 2'h1) ? 10'h100 :
                    (status_o.ratio_sel == 2'h2) ? 10'h180 : 10'h200;

  a_done_drops: assert property ($fell(active_low_reset_in_i) |-> ##[1:4] !status_o.init_done)
    else $error("done flag kept after reset pin fell");
  a_read_latency: assert property (core_req_i.en && !core_req_i.wr && status_o.init_done |-> ##2 core_rvalid_o)
    else $error("read answer missing two cycles after request");
  a_boot_refuse: assert property (!status_o.init_done [*5] |-> !core_rvalid_o)
    else $error("read answered before init finished");
  a_ctrl_cleared: assert property ($rose(status_o.init_done) |-> ctrl_regs_o == '0)
    else $error("control registers not zero at end of init");
  a_mult_code: assert property (status_o.init_done |-> status_o.in_multiple == mult_exp)
    else $error("clock multiple does not match select code");
  a_ratio_held: assert property (status_o.init_done && $past(status_o.init_done) |-> $stable(status_o.ratio_sel))
    else $error("ratio select changed while running");
  a_core_release: assert property ($rose(status_o.init_done) |-> ##[0:2] !status_o.core_reset)
    else $error("core reset not released after init");
  a_boot_length: assert property ($rose(status_o.init_done) |-> pin_cnt_reg >= MIN_BOOT)
    else $error("init finished too early");
endmodule : adbis_seq_props

bind adbis_seq adbis_seq_props #(.PLL_LOCK_EDGES(PLL_LOCK_EDGES)) props_u (
  .ref_clk_i(ref_clk_i),
  .rst_i(rst_i),
  .active_low_reset_in_i(active_low_reset_in_i),
  .core_req_i(core_req_i),
  .status_o(status_o),
  .core_rvalid_o(core_rvalid_o),
  .ctrl_regs_o(ctrl_regs_o)
);

// file: testbench/adbis_host.sv
`timescale 1ns/1ps

module adbis_host (
  input wire logic ref_clk_i,
  input wire logic pin_cmd_i,
  input wire logic [1:0] ratio_cmd_i,
  output logic active_low_reset_in_o,
  output logic clock_ratio_select_lo_o,
  output logic clock_ratio_select_hi_o,
  output logic master_clock_in_o
);
  logic [1:0] div_reg = 2'h0;

  initial
  begin
    active_low_reset_in_o = 1'b0;
    clock_ratio_select_lo_o = 1'b0;
    clock_ratio_select_hi_o = 1'b0;
  end

  // Select pins only move while the reset pin has been low a full cycle.
  always @(posedge ref_clk_i)
  begin
    div_reg <= div_reg + 2'h1;
    active_low_reset_in_o <= pin_cmd_i;
    if (!pin_cmd_i && !active_low_reset_in_o)
    begin
      clock_ratio_select_lo_o <= ratio_cmd_i[0];
      clock_ratio_select_hi_o <= ratio_cmd_i[1];
    end
  end

  // Quarter rate keeps the input clock under the sampling limit of the design.
  assign master_clock_in_o = div_reg[1];
endmodule : adbis_host

// file: testbench/adbis_seq_bench.sv
`timescale 1ns/1ps

module adbis_seq_bench;
  localparam int LOCK = 16;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic pin_cmd = 1'b1;
  logic [1:0] ratio_cmd = 2'h0;
  adbis_pkg::adbis_req_type core_req_i = '0;
  adbis_pkg::adbis_status_type status_o;
  logic [31:0] core_rdata_o;
  logic core_rvalid_o;
  logic [7:0][15:0] ctrl_regs_o;
  logic pin_w, lo_w, hi_w, mclk_w;
  int n_fail = 0;
  int n_compared = 0;
  logic [9:0] mult_tab [4] = '{10'h040, 10'h100, 10'h180, 10'h200};
  logic [7:0] route_tab [6] = '{8'h00, 8'h11, 8'h04, 8'h15, 8'h22, 8'h33};

  initial
    forever #10 ref_clk_i = ~ref_clk_i;

  adbis_host host_u (.ref_clk_i(ref_clk_i), .pin_cmd_i(pin_cmd), .ratio_cmd_i(ratio_cmd),
    .active_low_reset_in_o(pin_w), .clock_ratio_select_lo_o(lo_w), .clock_ratio_select_hi_o(hi_w),
    .master_clock_in_o(mclk_w));

  adbis_seq #(.PLL_LOCK_EDGES(LOCK)) dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .active_low_reset_in_i(pin_w), .clock_ratio_select_lo_i(lo_w), .clock_ratio_select_hi_i(hi_w),
    .master_clock_in_i(mclk_w), .core_req_i(core_req_i), .status_o(status_o), .core_rdata_o(core_rdata_o),
    .core_rvalid_o(core_rvalid_o), .ctrl_regs_o(ctrl_regs_o));

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : tick

  task automatic check(input logic ok, input string what);
    n_compared++;
    if (ok !== 1'b1)
    begin
      $display("MISMATCH %0t %s", $time, what);
      n_fail++;
    end
  endtask : check

  task automatic conclude();
    $display("Compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude

  task automatic start(input logic [1:0] code);
    pin_cmd = 1'b0;
    ratio_cmd = code;
    tick(6);
    pin_cmd = 1'b1;
  endtask : start

  task automatic wait_done(output int cyc);
    cyc = 0;
    while (status_o.init_done !== 1'b1 && cyc < 4000)
    begin
      tick(1);
      cyc++;
    end
    if (cyc >= 4000)
    begin
      $display("MISMATCH %0t init never finished", $time);
      n_fail++;
      conclude();
    end
  endtask : wait_done

  task automatic rd_chk(input logic [1:0] sel, input logic [5:0] a, input logic [31:0] exp);
    core_req_i = {2'b10, sel, a, 32'h00000000};
    tick(1);
    core_req_i.en = 1'b0;
    // The answer stands only in the cycle after the edge that follows the taking edge, so look there.
    tick(1);
    check(core_rvalid_o === 1'b1 && core_rdata_o === exp, "read answer");
  endtask : rd_chk

  task automatic wr(input logic [1:0] sel, input logic [5:0] a, input logic [31:0] d);
    core_req_i = {2'b11, sel, a, d};
    tick(1);
    core_req_i.en = 1'b0;
    // An idle edge keeps the next request from raising enable in this time step.
    tick(1);
  endtask : wr

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic test_powerup();
    int cyc;
    wait_done(cyc);
    check(status_o.ratio_sel === 2'h0 && status_o.in_multiple === 10'h040, "power-up mode");
  endtask : test_powerup

  task automatic test_ratios();
    int cyc;
    for (int c = 0; c < 4; c++)
    begin
      start(2'(c));
      wait_done(cyc);
      check(status_o.ratio_sel === 2'(c), "ratio code");
      check(status_o.in_multiple === mult_tab[c], "clock multiple");
      check(cyc >= 2048 + 4 * LOCK - 4 && cyc <= 2048 + 4 * LOCK + 16, "init length");
      check(ctrl_regs_o === '0, "control cleared");
      tick(3);
      check(status_o.core_reset === 1'b0, "core released");
    end
  endtask : test_ratios

  task automatic test_memories();
    for (int a = 0; a < 64; a++)
    begin
      rd_chk(2'h0, 6'(a), (a < 6) ? {4'h1, 20'h00000, route_tab[a]} : 32'h00000000);
      rd_chk(2'h1, 6'(a), (a < 6) ? 32'h00800000 : 32'h00000000);
      rd_chk(2'h2, 6'(a), 32'h00000000);
    end
  endtask : test_memories

  task automatic test_reboot();
    int cyc;
    wr(2'h2, 6'h05, 32'h0ABCDEF1);
    wr(2'h3, 6'h03, 32'h0000BEEF);
    rd_chk(2'h2, 6'h05, 32'h0ABCDEF1);
    check(ctrl_regs_o[3] === 16'hBEEF, "control write");
    rd_chk(2'h3, 6'h03, 32'h0000BEEF);
    start(2'h1);
    tick(300);
    core_req_i = {2'b10, 2'h2, 6'h05, 32'h00000000};
    tick(1);
    core_req_i.en = 1'b0;
    repeat (5)
    begin
      tick(1);
      check(core_rvalid_o === 1'b0, "read refused during init");
    end
    wait_done(cyc);
    rd_chk(2'h2, 6'h05, 32'h00000000);
    check(ctrl_regs_o === '0, "control cleared again");
  endtask : test_reboot

  initial
  begin
    tick(10);
    rst_i = 1'b0;
    test_powerup();
    test_ratios();
    test_memories();
    test_reboot();
    conclude();
  end
endmodule : adbis_seq_bench
